// *** rtl/cct_pkg.sv ***
/*
 * cct_pkg: constants and types of the capture/compare timer.
 * assumes a 16-bit register port with one-cycle read latency.
 */
package cct_pkg;
  // register indexes
  localparam logic [3:0] REG_CTRL_MODE = 4'h0;
  localparam logic [3:0] REG_CTRL_SYNC = 4'h1;
  localparam logic [3:0] REG_STATUS    = 4'h2;
  localparam logic [3:0] REG_TMR_LO    = 4'h3;
  localparam logic [3:0] REG_TMR_HI    = 4'h4;
  localparam logic [3:0] REG_PER_LO    = 4'h5;
  localparam logic [3:0] REG_PER_HI    = 4'h6;
  localparam logic [3:0] REG_CMP_PRI   = 4'h7;
  localparam logic [3:0] REG_CMP_SEC   = 4'h8;
  localparam logic [3:0] REG_CAP_LO    = 4'h9;
  localparam logic [3:0] REG_CAP_HI    = 4'hA;
  // mode register fields
  localparam int ENABLE_BIT   = 15;
  localparam int CLKSEL_LSB   = 8;
  localparam int PRESC_LSB    = 6;
  localparam int WIDE_BIT     = 5;
  localparam int CAPSEL_BIT   = 4;
  localparam int MODE_LSB     = 0;
  // sync register fields
  localparam int TRIGGER_OPERATION_ENABLE_BIT   = 7;
  localparam int SYNCSEL_LSB  = 0;
  // status register fields
  localparam int TRIG_ACT_BIT = 7;
  localparam int TRIG_CLR_BIT = 5;
  localparam int OVF_BIT      = 2;
  localparam int NEMPTY_BIT   = 1;
  localparam int EVENT_BIT    = 0;
  // reset values
  localparam logic [15:0] CTRL_MODE_RST = 16'h0000;
  localparam logic [15:0] CTRL_SYNC_RST = 16'h0000;
  localparam logic [15:0] PER_RST       = 16'hFFFF;
  // operating mode field codes
  localparam logic [3:0] MODE_TIMER    = 4'h0;
  localparam logic [3:0] MODE_OC_HIGH  = 4'h1;
  localparam logic [3:0] MODE_OC_LOW   = 4'h2;
  localparam logic [3:0] MODE_OC_TOG   = 4'h3;
  localparam logic [3:0] MODE_OC_DUAL  = 4'h4;
  localparam logic [3:0] MODE_OC_PWM   = 4'h5;
  localparam logic [3:0] MODE_IC_EDGE  = 4'h0;
  localparam logic [3:0] MODE_IC_RISE  = 4'h1;
  localparam logic [3:0] MODE_IC_FALL  = 4'h2;
  localparam logic [3:0] MODE_IC_BOTH  = 4'h3;
  localparam logic [3:0] MODE_IC_RISE4 = 4'h4;
  localparam logic [3:0] MODE_IC_RISE16 = 4'h5;
  localparam logic [2:0] CLKSEL_SYS    = 3'h0;
  // prescale terminal counts for 1:1, 1:4, 1:16, 1:64
  localparam logic [5:0] PRESC_END1  = 6'h00;
  localparam logic [5:0] PRESC_END4  = 6'h03;
  localparam logic [5:0] PRESC_END16 = 6'h0F;
  localparam logic [5:0] PRESC_END64 = 6'h3F;
  localparam logic [3:0] CAP_DIV4_END  = 4'h3;
  localparam logic [3:0] CAP_DIV16_END = 4'hF;
  localparam int CAP_DEPTH = 4;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cct_req_t;

  typedef enum logic [3:0] {
    MJ_OFF   = 4'b0001,
    MJ_TIMER = 4'b0010,
    MJ_OC    = 4'b0100,
    MJ_IC    = 4'b1000
  } cct_major_t;
endpackage

// *** rtl/cct_timer.sv ***
/*
 * cct_timer: timer, output compare/pwm and input capture unit.
 * assumes all inputs are synchronous to core_clk; clock sources 1 to 7 are
 * sampled as levels and their rising edges make the time base.
 */
`timescale 1ns/100ps
`default_nettype none

module cct_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire cct_pkg::cct_req_t bus_req,
  output logic [15:0]      rd_data,
  // time base and sync sources
  input  wire logic [7:0]  clk_src,
  input  wire logic [31:0] sync_in,
  // capture input
  input  wire logic        capture_in,
  // outputs
  output logic             cmp_out,
  output logic             sync_out,
  output logic             event_irq
);
  logic [15:0] ctrl_mode_q;
  logic [15:0] ctrl_sync_q;
  logic [15:0] tmr_lo_q;
  logic [15:0] tmr_hi_q;
  logic [15:0] per_lo_q;
  logic [15:0] per_hi_q;
  logic [15:0] cmp_pri_q;
  logic [15:0] cmp_sec_q;
  logic [15:0] pri_act_q;
  logic [15:0] sec_act_q;
  logic [7:0]  clk_src_q;
  logic [5:0]  presc_q;
  logic        trig_act_q;
  logic        event_flag_q;
  logic        ovf_q;
  logic        cap_in_q;
  logic [3:0]  cap_div_q;
  logic [31:0] cap_mem [cct_pkg::CAP_DEPTH];
  logic [1:0]  wr_ptr_q;
  logic [1:0]  rd_ptr_q;
  logic [2:0]  cap_cnt_q;
  logic        cmp_out_q;
  logic        sync_out_q;
  logic        event_irq_q;
  logic [15:0] rd_data_q;
  cct_pkg::cct_major_t major_q;

  logic        enable;
  logic [2:0]  clk_sel;
  logic [1:0]  presc_sel;
  logic        wide;
  logic [3:0]  mode;
  logic        trig_en;
  logic [4:0]  sync_sel;
  logic        src_tick;
  logic [5:0]  presc_end;
  logic        tick;
  logic        sync_hit;
  logic        hold;
  logic        lo_match;
  logic        hi_match;
  logic        wide_match;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        cap_rise;
  logic        cap_fall;
  logic        cap_event;
  logic        cap_push;
  logic        cap_pop;
  logic        run_timer;
  logic        run_oc;
  logic        run_ic;
  logic        pri_match;
  logic        sec_match;

  assign addr      = bus_req.addr;
  assign wdata     = bus_req.wdata;
  assign wr        = bus_req.wr;
  assign rd        = bus_req.rd;
  assign enable    = ctrl_mode_q[cct_pkg::ENABLE_BIT];
  assign clk_sel   = ctrl_mode_q[cct_pkg::CLKSEL_LSB +: 3];
  assign presc_sel = ctrl_mode_q[cct_pkg::PRESC_LSB +: 2];
  assign wide      = ctrl_mode_q[cct_pkg::WIDE_BIT];
  assign mode      = ctrl_mode_q[cct_pkg::MODE_LSB +: 4];
  assign trig_en   = ctrl_sync_q[cct_pkg::TRIGGER_OPERATION_ENABLE_BIT];
  assign sync_sel  = ctrl_sync_q[cct_pkg::SYNCSEL_LSB +: 5];

  // major mode decode; a new mode takes effect by rewriting the field
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      major_q <= cct_pkg::MJ_OFF;
    end else if (!enable) begin
      major_q <= cct_pkg::MJ_OFF;
    end else if (ctrl_mode_q[cct_pkg::CAPSEL_BIT]) begin
      major_q <= cct_pkg::MJ_IC;
    end else if (mode == cct_pkg::MODE_TIMER) begin
      major_q <= cct_pkg::MJ_TIMER;
    end else begin
      major_q <= cct_pkg::MJ_OC;
    end
  end

  always_comb begin
    run_timer = 1'b0;
    run_oc    = 1'b0;
    run_ic    = 1'b0;
    case (major_q)
      cct_pkg::MJ_TIMER: run_timer = 1'b1;
      cct_pkg::MJ_OC:    run_oc    = 1'b1;
      cct_pkg::MJ_IC:    run_ic    = 1'b1;
      default:           run_timer = 1'b0;
    endcase
  end

  // time base: selected source edge, then prescaler
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_src_q <= 8'h00;
    end else begin
      clk_src_q <= clk_src;
    end
  end

  // source 0 is the system clock itself: a tick every cycle
  assign src_tick = (clk_sel == cct_pkg::CLKSEL_SYS) ? 1'b1 :
                    (clk_src[clk_sel] & ~clk_src_q[clk_sel]);

  always_comb begin
    case (presc_sel)
      2'h0:    presc_end = cct_pkg::PRESC_END1;
      2'h1:    presc_end = cct_pkg::PRESC_END4;
      2'h2:    presc_end = cct_pkg::PRESC_END16;
      default: presc_end = cct_pkg::PRESC_END64;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_q <= 6'h00;
    end else if (major_q == cct_pkg::MJ_OFF) begin
      presc_q <= 6'h00;
    end else if (src_tick) begin
      presc_q <= (presc_q >= presc_end) ? 6'h00 : presc_q + 6'h01;
    end
  end

  assign tick = src_tick && (presc_q >= presc_end);

  // sync and trigger control
  assign sync_hit = sync_in[sync_sel];
  // held at zero until a trigger arrives
  assign hold     = trig_en && !trig_act_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_act_q <= 1'b0;
    end else if (!enable || !trig_en) begin
      trig_act_q <= 1'b0;
    end else if (sync_hit && !run_ic) begin
      trig_act_q <= 1'b1;
    end else if (wr && addr == cct_pkg::REG_STATUS &&
                 wdata[cct_pkg::TRIG_CLR_BIT]) begin
      trig_act_q <= 1'b0;
    end
  end

  // period compare, shared by timer and compare modes
  assign lo_match   = (tmr_lo_q == per_lo_q);
  assign hi_match   = (tmr_hi_q == per_hi_q);
  assign wide_match = lo_match && hi_match;

  // shared counter pair; capture runs it free
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_lo_q <= 16'h0000;
      tmr_hi_q <= 16'h0000;
    end else if (wr && addr == cct_pkg::REG_TMR_LO) begin
      tmr_lo_q <= wdata;
    end else if (wr && addr == cct_pkg::REG_TMR_HI) begin
      tmr_hi_q <= wdata;
    end else if (major_q == cct_pkg::MJ_OFF) begin
      tmr_lo_q <= 16'h0000;
      tmr_hi_q <= 16'h0000;
    end else if (!run_ic && (hold || (!trig_en && sync_hit))) begin
      tmr_lo_q <= 16'h0000;
      if (wide) begin
        tmr_hi_q <= 16'h0000;
      end
    end else if (tick) begin
      if (run_ic) begin
        tmr_lo_q <= tmr_lo_q + 16'h0001;
        if (wide && tmr_lo_q == 16'hFFFF) begin
          tmr_hi_q <= tmr_hi_q + 16'h0001;
        end
      end else if (wide) begin
        if (wide_match) begin
          tmr_lo_q <= 16'h0000;
          tmr_hi_q <= 16'h0000;
        end else begin
          tmr_lo_q <= tmr_lo_q + 16'h0001;
          if (tmr_lo_q == 16'hFFFF) begin
            tmr_hi_q <= tmr_hi_q + 16'h0001;
          end
        end
      end else begin
        tmr_lo_q <= lo_match ? 16'h0000 : tmr_lo_q + 16'h0001;
        if (run_timer) begin
          tmr_hi_q <= hi_match ? 16'h0000 :
                      tmr_hi_q + 16'h0001;
        end
      end
    end
  end

  // compare values; pwm takes new values at the period boundary
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pri_act_q <= 16'h0000;
      sec_act_q <= 16'h0000;
    end else if (mode != cct_pkg::MODE_OC_PWM || !run_oc ||
                 (tick && lo_match)) begin
      pri_act_q <= cmp_pri_q;
      sec_act_q <= cmp_sec_q;
    end
  end

  assign pri_match = wide ? ({tmr_hi_q, tmr_lo_q} ==
                             {sec_act_q, pri_act_q})
                          : (tmr_lo_q == pri_act_q);
  assign sec_match = (tmr_lo_q == sec_act_q);

  // single compare output of the one-output variant
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_out_q <= 1'b0;
    end else if (!run_oc) begin
      cmp_out_q <= 1'b0;
    end else if (tick) begin
      case (mode)
        cct_pkg::MODE_OC_HIGH: begin
          if (pri_match) cmp_out_q <= 1'b1;
        end
        cct_pkg::MODE_OC_LOW: begin
          if (pri_match) cmp_out_q <= 1'b0;
        end
        cct_pkg::MODE_OC_TOG: begin
          if (pri_match) cmp_out_q <= ~cmp_out_q;
        end
        cct_pkg::MODE_OC_DUAL, cct_pkg::MODE_OC_PWM: begin
          if (sec_match) begin
            cmp_out_q <= 1'b0;
          end else if (tmr_lo_q == pri_act_q) begin
            cmp_out_q <= 1'b1;
          end
        end
        default: cmp_out_q <= cmp_out_q;
      endcase
    end
  end

  // event pulses: sync out and interrupt request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_out_q  <= 1'b0;
      event_irq_q <= 1'b0;
    end else begin
      sync_out_q  <= tick && (run_timer || run_oc) && !hold &&
                     (wide ? wide_match : lo_match);
      if (run_timer) begin
        event_irq_q <= tick && !hold &&
                       (wide ? wide_match : hi_match);
      end else if (run_oc) begin
        event_irq_q <= tick && (pri_match ||
                       (mode >= cct_pkg::MODE_OC_DUAL && sec_match));
      end else begin
        event_irq_q <= cap_push;
      end
    end
  end

  // capture edge selection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_in_q <= 1'b0;
    end else begin
      cap_in_q <= capture_in;
    end
  end

  assign cap_rise = capture_in && !cap_in_q;
  assign cap_fall = !capture_in && cap_in_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_div_q <= 4'h0;
    end else if (!run_ic) begin
      cap_div_q <= 4'h0;
    end else if (cap_rise) begin
      cap_div_q <= cap_event ? 4'h0 : cap_div_q + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      cct_pkg::MODE_IC_EDGE, cct_pkg::MODE_IC_BOTH:
        cap_event = cap_rise || cap_fall;
      cct_pkg::MODE_IC_RISE:   cap_event = cap_rise;
      cct_pkg::MODE_IC_FALL:   cap_event = cap_fall;
      cct_pkg::MODE_IC_RISE4:
        cap_event = cap_rise && cap_div_q == cct_pkg::CAP_DIV4_END;
      cct_pkg::MODE_IC_RISE16:
        cap_event = cap_rise && cap_div_q == cct_pkg::CAP_DIV16_END;
      default:                 cap_event = 1'b0;
    endcase
  end

  // capture fifo; a full fifo drops the event and flags overflow
  assign cap_push = run_ic && cap_event && cap_cnt_q != 3'(cct_pkg::CAP_DEPTH);
  assign cap_pop  = rd && addr == cct_pkg::REG_CAP_LO &&
                    cap_cnt_q != 3'h0;

  always_ff @(posedge core_clk) begin
    if (cap_push) begin
      cap_mem[wr_ptr_q] <= {wide ? tmr_hi_q : 16'h0000,
                            tmr_lo_q};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q  <= 2'h0;
      rd_ptr_q  <= 2'h0;
      cap_cnt_q <= 3'h0;
    end else if (!run_ic) begin
      wr_ptr_q  <= 2'h0;
      rd_ptr_q  <= 2'h0;
      cap_cnt_q <= 3'h0;
    end else begin
      if (cap_push) wr_ptr_q <= wr_ptr_q + 2'h1;
      if (cap_pop)  rd_ptr_q <= rd_ptr_q + 2'h1;
      cap_cnt_q <= cap_cnt_q + 3'(cap_push) - 3'(cap_pop);
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_flag_q <= 1'b0;
      ovf_q        <= 1'b0;
    end else begin
      if (event_irq_q) begin
        event_flag_q <= 1'b1;
      end else if (wr && addr == cct_pkg::REG_STATUS &&
                   wdata[cct_pkg::EVENT_BIT]) begin
        event_flag_q <= 1'b0;
      end
      if (run_ic && cap_event && !cap_push) begin
        ovf_q <= 1'b1;
      end else if (wr && addr == cct_pkg::REG_STATUS &&
                   wdata[cct_pkg::OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_mode_q <= cct_pkg::CTRL_MODE_RST;
      ctrl_sync_q <= cct_pkg::CTRL_SYNC_RST;
      per_lo_q    <= cct_pkg::PER_RST;
      per_hi_q    <= cct_pkg::PER_RST;
      cmp_pri_q   <= 16'h0000;
      cmp_sec_q   <= 16'h0000;
    end else if (wr) begin
      if (addr == cct_pkg::REG_CTRL_MODE) begin
        ctrl_mode_q <= wdata & 16'h87FF;
      end else if (addr == cct_pkg::REG_CTRL_SYNC) begin
        ctrl_sync_q <= wdata & 16'h009F;
      end else if (addr == cct_pkg::REG_PER_LO) begin
        per_lo_q <= wdata;
      end else if (addr == cct_pkg::REG_PER_HI) begin
        per_hi_q <= wdata;
      end else if (addr == cct_pkg::REG_CMP_PRI) begin
        cmp_pri_q <= wdata;
      end else if (addr == cct_pkg::REG_CMP_SEC) begin
        cmp_sec_q <= wdata;
      end
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (rd) begin
      if (addr == cct_pkg::REG_CTRL_MODE) begin
        rd_data_q <= ctrl_mode_q;
      end else if (addr == cct_pkg::REG_CTRL_SYNC) begin
        rd_data_q <= ctrl_sync_q;
      end else if (addr == cct_pkg::REG_STATUS) begin
        rd_data_q <= {8'h00, trig_act_q, 4'h0, ovf_q,
                      cap_cnt_q != 3'h0, event_flag_q};
      end else if (addr == cct_pkg::REG_TMR_LO) begin
        rd_data_q <= tmr_lo_q;
      end else if (addr == cct_pkg::REG_TMR_HI) begin
        rd_data_q <= tmr_hi_q;
      end else if (addr == cct_pkg::REG_PER_LO) begin
        rd_data_q <= per_lo_q;
      end else if (addr == cct_pkg::REG_PER_HI) begin
        rd_data_q <= per_hi_q;
      end else if (addr == cct_pkg::REG_CMP_PRI) begin
        rd_data_q <= cmp_pri_q;
      end else if (addr == cct_pkg::REG_CMP_SEC) begin
        rd_data_q <= cmp_sec_q;
      end else if (addr == cct_pkg::REG_CAP_LO) begin
        rd_data_q <= cap_mem[rd_ptr_q][15:0];
      end else if (addr == cct_pkg::REG_CAP_HI) begin
        rd_data_q <= cap_mem[rd_ptr_q][31:16];
      end else begin
        rd_data_q <= 16'h0000;
      end
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  assign rd_data   = rd_data_q;
  assign cmp_out   = cmp_out_q;
  assign sync_out  = sync_out_q;
  assign event_irq = event_irq_q;
endmodule

`default_nettype wire

// *** tb/cct_pins_model.sv ***
/*
 * cct_pins_model: pins and peer units around the timer.
 * assumes the bench asks for levels just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module cct_pins_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // requests from the bench
  input  wire logic [4:0]  sel,
  input  wire logic        sync_lvl,
  input  wire logic        cap_lvl,
  // pins
  output logic [7:0]       clk_src,
  output logic [31:0]      sync_in,
  output logic             capture_in
);
  logic [31:0] noise_q;

  // unused lines except clock line 0, tied low, keep changing so a stale level never looks valid
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      noise_q <= 32'h0000_0000;
    end else begin
      noise_q <= noise_q + 32'h9E37_79B9;
    end
  end

  always_comb begin
    sync_in = noise_q;
    sync_in[sel] = sync_lvl;
    clk_src = {noise_q[7:1], 1'b0};
    capture_in = cap_lvl;
  end
endmodule
`default_nettype wire

// *** tb/cct_timer_sva.sv ***
/*
 * cct_timer_sva: port checks of the capture/compare timer.
 * assumes it is bound to cct_timer and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module cct_timer_sva (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // register port
  input wire cct_pkg::cct_req_t bus_req,
  input wire logic [15:0]       rd_data,
  // pins
  input wire logic [7:0]        clk_src,
  input wire logic [31:0]       sync_in,
  input wire logic              capture_in,
  input wire logic              cmp_out,
  input wire logic              sync_out,
  input wire logic              event_irq
);
  logic [15:0] m_q;
  logic [15:0] p_q;
  logic [7:0]  s_q;
  logic [31:0] g_q;
  logic [3:0]  st_q, w_q, h_q, c_q;
  logic        arm_q, ok_q, cap_q, wr_m, hit, tmr;

  assign wr_m = bus_req.wr && bus_req.addr == cct_pkg::REG_CTRL_MODE;
  assign hit  = sync_in[s_q[4:0]];
  assign tmr  = m_q[15] && m_q[4:0] == 5'h00;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // shadows of what software wrote
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      m_q <= 16'h0000;
      s_q <= 8'h00;
      p_q <= 16'hFFFF;
    end else if (bus_req.wr) begin
      if (wr_m)
        m_q <= bus_req.wdata;
      if (bus_req.addr == cct_pkg::REG_CTRL_SYNC)
        s_q <= bus_req.wdata[7:0];
      if (bus_req.addr == cct_pkg::REG_PER_LO)
        p_q <= bus_req.wdata;
    end
  end

  // a trigger wait lasts until the selected input is seen high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arm_q <= 1'b0;
    end else if (hit) begin
      arm_q <= 1'b0;
    end else if (bus_req.wr && (bus_req.addr == cct_pkg::REG_CTRL_SYNC ||
               (bus_req.addr == cct_pkg::REG_STATUS && bus_req.wdata[5]))) begin
      arm_q <= 1'b1;
    end
  end

  // saturating counts; four cycles cover the decode and pulse lag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= 4'h0;
      w_q <= 4'h0;
      h_q <= 4'h0;
      c_q <= 4'h0;
      cap_q <= 1'b0;
    end else begin
      st_q <= wr_m ? 4'h0 : st_q + {3'h0, st_q != 4'hF};
      w_q <= !(arm_q && tmr && s_q[7]) ? 4'h0 : w_q + {3'h0, w_q != 4'hF};
      h_q <= !(tmr && !s_q[7] && hit) ? 4'h0 : h_q + {3'h0, h_q != 4'hF};
      c_q <= wr_m ? 4'h0 : c_q + {3'h0, capture_in && !cap_q && c_q != 4'hF};
      cap_q <= capture_in;
    end
  end

  // gap between primary pulses, trusted only in a quiet plain timer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      g_q <= 32'h0000_0000;
      ok_q <= 1'b0;
    end else begin
      g_q <= sync_out ? 32'h0000_0001 : g_q + 32'h0000_0001;
      if (bus_req.wr || hit || !tmr || s_q[7] || m_q[5] || m_q[10:8] != 3'h0)
        ok_q <= 1'b0;
      else if (sync_out)
        ok_q <= 1'b1;
    end
  end

  property p_off;
    st_q > 4'h3 && !m_q[15] |-> !cmp_out && !sync_out;
  endproperty
  a_off: assert property (p_off)
    else $error("output active while disabled");

  property p_tmr_out;
    st_q > 4'h3 && tmr |-> !cmp_out;
  endproperty
  a_tmr_out: assert property (p_tmr_out)
    else $error("compare output driven in timer mode");

  property p_oc_hi;
    st_q > 4'h3 && m_q[15] && m_q[4:0] == 5'h01 |-> !$fell(cmp_out);
  endproperty
  a_oc_hi: assert property (p_oc_hi)
    else $error("output fell in drive high mode");

  property p_oc_lo;
    st_q > 4'h3 && m_q[15] && m_q[4:0] == 5'h02 |-> !$rose(cmp_out);
  endproperty
  a_oc_lo: assert property (p_oc_lo)
    else $error("output rose in drive low mode");

  property p_trig;
    w_q > 4'h3 && p_q != 16'h0000 |-> !sync_out;
  endproperty
  a_trig: assert property (p_trig)
    else $error("timer ran before its trigger");

  property p_sync;
    h_q > 4'h3 && p_q != 16'h0000 |-> !sync_out;
  endproperty
  a_sync: assert property (p_sync)
    else $error("timer not held clear by sync input");

  property p_gap;
    sync_out && ok_q |-> g_q == ((32'(p_q) + 32'h1) << {m_q[7:6], 1'b0});
  endproperty
  a_gap: assert property (p_gap)
    else $error("primary period length wrong");

  property p_cap;
    m_q[15] && m_q[4:0] == 5'h11 && st_q > 4'h3 && c_q < 4'h4 &&
      capture_in && !cap_q |-> ##[1:3] event_irq;
  endproperty
  a_cap: assert property (p_cap)
    else $error("rising capture raised no event");
endmodule

bind cct_timer cct_timer_sva u_sva (.core_clk, .rst, .bus_req, .rd_data,
  .clk_src, .sync_in, .capture_in, .cmp_out, .sync_out, .event_irq);
`default_nettype wire

// *** tb/testbench.sv ***
/*
 * testbench: random and corner runs of the capture/compare timer.
 * assumes cct_pins_model drives the pins and the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic              core_clk, rst, cmp_out, sync_out, event_irq;
  logic              capture_in, sync_lvl, cap_lvl;
  cct_pkg::cct_req_t bus_req;
  logic [15:0]       rd_data, v, p, q, a, b;
  logic [7:0]        clk_src;
  logic [31:0]       sync_in;
  logic [4:0]        sel;
  int                err_count, num_checks, cyc, seed, n;
  int                ts0, ts1, te0, te1, ne, nh;

  cct_timer DUT (.core_clk, .rst, .bus_req, .rd_data, .clk_src, .sync_in,
    .capture_in, .cmp_out, .sync_out, .event_irq);
  cct_pins_model u_pins (.core_clk, .rst, .sel, .sync_lvl, .cap_lvl,
    .clk_src, .sync_in, .capture_in);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] per_cyc(input logic [15:0] pr, input int ps);
    return (32'(pr) + 32'h1) << (2 * ps);
  endfunction

  function automatic logic [31:0] oc_high(input int md,
                                          input logic [15:0] pr, c1, c2);
    case (md)
      1: return 32'(4 * (pr + 1));
      3: return 32'(2 * (pr + 1));
      4, 5: return 32'(4 * (c2 - c1));
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] cap_evt(input int md);
    case (md)
      0, 3: return 32'h20;
      1, 2: return 32'h10;
      4: return 32'h4;
      default: return 32'h1;
    endcase
  endfunction

  task automatic results;
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{ad, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{ad, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 d = rd_data;
  endtask

  // rising edges of the capture pin come seven cycles apart
  task automatic pulse;
    @(posedge core_clk);
    cap_lvl <= 1'b1;
    tick(3);
    cap_lvl <= 1'b0;
    tick(3);
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    nh <= nh + int'(cmp_out);
    if (sync_out) begin
      ts1 <= ts0;
      ts0 <= cyc;
    end
    if (event_irq) begin
      te1 <= te0;
      te0 <= cyc;
      ne <= ne + 1;
    end
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end

  initial begin
    seed = 32'h1D6B;
    rst = 1'b1;
    bus_req = '0;
    sel = 5'h00;
    sync_lvl = 1'b0;
    cap_lvl = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wr(4'hF, 16'hFFFF);
    rd(4'hF, v);
    chk("unmapped", 0, v);
    rd(cct_pkg::REG_CTRL_MODE, v);
    chk("mode reset", 0, v);
    rd(cct_pkg::REG_PER_LO, v);
    chk("period reset", 32'hFFFF, v);
    for (int ps = 0; ps < 4; ps++) begin
      p = 16'(3 + ($random(seed) & 7));
      q = 16'(3 + ($random(seed) & 7));
      wr(cct_pkg::REG_CTRL_MODE, 16'h0000);
      wr(cct_pkg::REG_PER_LO, p);
      wr(cct_pkg::REG_PER_HI, q);
      wr(cct_pkg::REG_CTRL_MODE, 16'(32'h8000 | ps << 6));
      tick(3 * (p + q + 2) << (2 * ps));
      chk("primary period", per_cyc(p, ps), ts0 - ts1);
      chk("secondary period", per_cyc(q, ps), te0 - te1);
    end
    wr(cct_pkg::REG_CTRL_MODE, 16'h8020);
    wr(cct_pkg::REG_TMR_HI, 16'h0000);
    wr(cct_pkg::REG_TMR_LO, 16'hFFF0);
    tick(30);
    rd(cct_pkg::REG_TMR_HI, v);
    chk("wide carry", 1, v);
    wr(cct_pkg::REG_CTRL_MODE, 16'h8000);
    wr(cct_pkg::REG_PER_LO, 16'hFFFF);
    b = 16'($random(seed)) & 16'h001E;
    sel <= b[4:0];
    wr(cct_pkg::REG_CTRL_SYNC, b);
    sync_lvl <= 1'b1;
    tick(5);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("sync clear", 0, v);
    sync_lvl <= 1'b0;
    tick(5);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("sync recount", 1, v != 16'h0000);
    wr(cct_pkg::REG_CTRL_SYNC, 16'h0080 | b);
    tick(5);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("trigger hold", 0, v);
    rd(cct_pkg::REG_STATUS, v);
    chk("trigger idle flag", 0, v[7]);
    sync_lvl <= 1'b1;
    tick(1);
    sync_lvl <= 1'b0;
    tick(5);
    rd(cct_pkg::REG_STATUS, v);
    chk("trigger flag", 1, v[7]);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("trigger run", 1, v != 16'h0000);
    wr(cct_pkg::REG_STATUS, 16'h0020);
    tick(3);
    rd(cct_pkg::REG_STATUS, v);
    chk("trigger flag clear", 0, v[7]);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("trigger zero", 0, v);
    wr(cct_pkg::REG_CTRL_SYNC, b);
    wr(cct_pkg::REG_CTRL_MODE, 16'h0000);
    tick(5);
    rd(cct_pkg::REG_TMR_LO, v);
    chk("disabled count", 0, v);
    p = 16'(8 + ($random(seed) & 7));
    a = 16'(1 + ($random(seed) & 1));
    q = a + 16'(2 + ($random(seed) & 3));
    wr(cct_pkg::REG_PER_LO, p);
    wr(cct_pkg::REG_CMP_PRI, a);
    wr(cct_pkg::REG_CMP_SEC, q);
    for (int md = 1; md < 6; md++) begin
      wr(cct_pkg::REG_CTRL_MODE, 16'(32'h8000 | md));
      tick(3 * (p + 1));
      n = nh;
      b = 16'(ne);
      tick(4 * (p + 1));
      chk("output high time", oc_high(md, p, a, q), nh - n);
      chk("compare events", md > 3 ? 8 : 4, ne - b);
    end
    for (int md = 0; md < 6; md++) begin
      wr(cct_pkg::REG_CTRL_MODE, 16'h0000);
      wr(cct_pkg::REG_CTRL_MODE, 16'(32'h8010 | md));
      tick(4);
      n = ne;
      repeat (16) begin
        pulse();
        rd(cct_pkg::REG_CAP_LO, v);
        rd(cct_pkg::REG_CAP_LO, v);
      end
      tick(4);
      chk("capture events", cap_evt(md), ne - n);
    end
    wr(cct_pkg::REG_CTRL_MODE, 16'h0000);
    wr(cct_pkg::REG_CTRL_MODE, 16'h8031);
    wr(cct_pkg::REG_TMR_HI, 16'h0005);
    tick(4);
    repeat (5) pulse();
    tick(4);
    rd(cct_pkg::REG_STATUS, v);
    chk("fifo full flags", 32'h3, v[2:1]);
    rd(cct_pkg::REG_CAP_HI, v);
    chk("capture high", 5, v);
    rd(cct_pkg::REG_CAP_LO, a);
    rd(cct_pkg::REG_CAP_LO, q);
    chk("capture spacing", 7, q - a);
    rd(cct_pkg::REG_CAP_LO, v);
    rd(cct_pkg::REG_CAP_LO, v);
    rd(cct_pkg::REG_STATUS, v);
    chk("fifo drained", 0, v[1]);
    results();
  end
endmodule
`default_nettype wire
